// File: rtl/srbc_defines.vh
// Reset and droop control: offsets, fields, timing.
// Assumes a 250 MHz core clock.
`ifndef SRBC_DEFINES_VH
`define SRBC_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SRBC_OFS_STATUS   12'h000
`define SRBC_OFS_ENABLE   12'h004
`define SRBC_OFS_CLEAR    12'h008
`define SRBC_OFS_RAW      12'h00C
`define SRBC_OFS_MEMMAP   12'h010
`define SRBC_OFS_GUARD    12'h014
`define SRBC_OFS_RSTSRC   12'h018
`define SRBC_OFS_EXTCFG   12'h01C

// ----------------------------------------
// Event bit positions (status, enable, clear)
// ----------------------------------------
`define SRBC_EV_DROOP     0
`define SRBC_EV_EXTWAKE   1
`define SRBC_EV_FLASHRDY  2
`define SRBC_EV_W         3

// ----------------------------------------
// Reset source bits
// ----------------------------------------
`define SRBC_SRC_PIN      0
`define SRBC_SRC_WDT      1
`define SRBC_SRC_POR      2
`define SRBC_SRC_DROOP    3

// ----------------------------------------
// Vector window selection
// ----------------------------------------
`define SRBC_MAP_BOOTROM  2'h0
`define SRBC_MAP_SRAM     2'h1
`define SRBC_MAP_EXTMEM   2'h2

// ----------------------------------------
// Guard patterns held in the flash guard word
// ----------------------------------------
`define SRBC_PAT_PARTIAL  32'h12345678
`define SRBC_PAT_FULLERA  32'h87654321
`define SRBC_PAT_LOCKED   32'h43218765

`define SRBC_LVL_NONE     2'h0
`define SRBC_LVL_PARTIAL  2'h1
`define SRBC_LVL_FULLERA  2'h2
`define SRBC_LVL_LOCKED   2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define SRBC_CLK_MHZ         250
`define SRBC_WAKE_CLKS       16'h0400
`define SRBC_FLASH_WAKE_US   100
`define SRBC_FLASH_WAKE_CLKS 16'h61A8
`define SRBC_CNT_W           16

`define SRBC_EXT_N           4

`endif

// File: rtl/srbc_sync3.v
// Three-stage input synchroniser with agreement filter.
// Assumes d_i is asynchronous; q_o follows once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module srbc_sync3 #(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    input  wire         clk_i,
    input  wire         nrst_i,
    input  wire [W-1:0] d_i,
    output reg  [W-1:0] q_o
);

    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    reg [W-1:0] s3_r;
    integer     k;

    always @(posedge clk_i) begin
        if (!nrst_i) begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
            q_o  <= INIT;
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (k = 0; k < W; k = k + 1) begin
                if (s2_r[k] == s3_r[k]) begin
                    q_o[k] <= s3_r[k];
                end
            end
        end
    end

endmodule // srbc_sync3

`default_nettype wire

// File: rtl/srbc_top.v
// Reset and droop control with APB slave.
// Assumes level comparator flags and a flash guard word;
// async inputs are synchronised here.
//
// Contract
// - Internal reset comes from the pin, watchdog, power-on or droop reset.
// - Any source restarts the wake-up count; reset holds until pin release, oscillator, count and flash init.
// - On release the core fetches at address 0 via boot ROM with status, enable, map and external config registers at reset values.
// - A supply below 2.95 V raises the first droop request to the interrupt controller.
// - The request interrupts only when enabled and is always readable in a status bit.
// - A supply below 2.65 V asserts chip reset to protect flash.
// - Droop reset holds down to about 1 V, then power-on detection holds reset.
// - Both droop thresholds use hysteresis.
// - The guard level is decoded from a flash word pattern and never limits application flash calls.
// - Partial guard blocks debug and allows a loader subset that spares sector 0.
// - Full-erase guard blocks debug and allows only erase-all-then-program loading.
// - Locked guard blocks debug and the loader, including override-pin entry.
// - A mapping control serves the vector window at 0x0000 0000 from boot ROM, SRAM or external memory.
// - Up to 68 edge inputs plus up to four level external inputs are offered.
// - An enabled external interrupt input can wake the core from power-down.
// - After power-down wake, flash access waits 100 us.
`timescale 1ns/1ps
`default_nettype none
`include "srbc_defines.vh"

module srbc_top (
    input  wire        CORE_CLK_I,
    input  wire        NRST_I,
    // APB slave
    input  wire        PSEL_I,
    input  wire        PENABLE_I,
    input  wire        PWRITE_I,
    input  wire [11:0] PADDR_I,
    input  wire [31:0] PWDATA_I,
    output reg  [31:0] PRDATA_O,
    output reg         PREADY_O,
    output reg         PSLVERR_O,
    // Reset sources and analogue flags (asynchronous)
    input  wire        RESET_PIN_N_I,
    input  wire        WDT_RESET_I,
    input  wire        POR_I,
    input  wire        DROOP_IRQ_LOW_I,
    input  wire        DROOP_IRQ_HIGH_I,
    input  wire        DROOP_RST_LOW_I,
    input  wire        DROOP_RST_HIGH_I,
    input  wire        OSC_RUNNING_I,
    // Flash controller
    input  wire        FLASH_INIT_DONE_I,
    input  wire [31:0] GUARD_WORD_I,
    input  wire        GUARD_WORD_VALID_I,
    // Wake and external interrupts
    input  wire        POWER_DOWN_I,
    input  wire [3:0]  EXT_IRQ_I,
    input  wire [67:0] EDGE_IRQ_I,
    // Outputs
    output reg         SYS_RST_N_O,
    output reg         DROOP_IRQ_O,
    output reg         IRQ_O,
    output reg  [3:0]  EXT_IRQ_O,
    output reg  [67:0] EDGE_IRQ_O,
    output reg         WAKE_O,
    output reg         FLASH_ACCESS_OK_O,
    output reg  [1:0]  VECTOR_MAP_O,
    output reg  [1:0]  GUARD_LEVEL_O,
    output reg         DEBUG_BLOCK_O,
    output reg         LOADER_ALLOW_O,
    output reg         LOADER_OVERRIDE_ALLOW_O,
    output reg         LOADER_SECTOR0_BLOCK_O,
    output reg         LOADER_FULL_ERASE_ONLY_O,
    output reg         APP_FLASH_CALLS_ALLOW_O
);

    // ----------------------------------------
    // State machine codes
    // ----------------------------------------
    localparam [3:0] ST_HOLD  = 4'h1;
    localparam [3:0] ST_COUNT = 4'h2;
    localparam [3:0] ST_FLASH = 4'h4;
    localparam [3:0] ST_RUN   = 4'h8;

    localparam [`SRBC_CNT_W-1:0] WAKE_CNT  = `SRBC_WAKE_CLKS;
    localparam [`SRBC_CNT_W-1:0] FLASH_CNT = `SRBC_FLASH_WAKE_CLKS;

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function [1:0] guard_decode;
        input [31:0] w;
        begin
            case (w)
                `SRBC_PAT_PARTIAL: guard_decode = `SRBC_LVL_PARTIAL;
                `SRBC_PAT_FULLERA: guard_decode = `SRBC_LVL_FULLERA;
                `SRBC_PAT_LOCKED:  guard_decode = `SRBC_LVL_LOCKED;
                default:           guard_decode = `SRBC_LVL_NONE;
            endcase
        end
    endfunction

    // Set on the low trip, clear on the high trip
    function hyst;
        input cur;
        input below_low;
        input above_high;
        begin
            if (below_low) begin
                hyst = 1'b1;
            end else if (above_high) begin
                hyst = 1'b0;
            end else begin
                hyst = cur;
            end
        end
    endfunction

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    wire [8:0] async_in;
    wire [8:0] sync_out;
    assign async_in = {FLASH_INIT_DONE_I, OSC_RUNNING_I, DROOP_RST_HIGH_I, DROOP_RST_LOW_I,
                       DROOP_IRQ_HIGH_I, DROOP_IRQ_LOW_I, POR_I, WDT_RESET_I, RESET_PIN_N_I};

    srbc_sync3 #(
        .W    (9),
        .INIT (9'h001)
    ) u_sync (
        .clk_i  (CORE_CLK_I),
        .nrst_i (NRST_I),
        .d_i    (async_in),
        .q_o    (sync_out)
    );

    wire [3:0] ext_sync;
    srbc_sync3 #(
        .W    (4),
        .INIT (4'h0)
    ) u_sync_ext (
        .clk_i  (CORE_CLK_I),
        .nrst_i (NRST_I),
        .d_i    (EXT_IRQ_I),
        .q_o    (ext_sync)
    );

    wire pin_n_s    = sync_out[0];
    wire wdt_s      = sync_out[1];
    wire por_s      = sync_out[2];
    wire irq_low_s  = sync_out[3];
    wire irq_high_s = sync_out[4];
    wire rst_low_s  = sync_out[5];
    wire rst_high_s = sync_out[6];
    wire osc_s      = sync_out[7];
    wire finit_s    = sync_out[8];

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg                    droop_irq_r;
    reg                    droop_rst_r;
    reg [3:0]              state_r;
    reg [`SRBC_CNT_W-1:0]  cnt_r;
    reg [`SRBC_CNT_W-1:0]  fcnt_r;
    reg                    fwait_r;
    reg                    pd_r;
    reg [`SRBC_EV_W-1:0]   status_r;
    reg [`SRBC_EV_W-1:0]   enable_r;
    reg [1:0]              memmap_r;
    reg [3:0]              rstsrc_r;
    reg [3:0]              ext_wake_en_r;
    reg [3:0]              ext_en_r;
    reg [1:0]              guard_r;
    reg                    guard_ok_r;

    // ----------------------------------------
    // Droop detection with hysteresis
    // ----------------------------------------
    always @(posedge CORE_CLK_I) begin
        if (!NRST_I) begin
            droop_irq_r <= 1'b0;
            droop_rst_r <= 1'b0;
        end else begin
            droop_irq_r <= hyst(droop_irq_r, irq_low_s, irq_high_s);
            droop_rst_r <= hyst(droop_rst_r, rst_low_s, rst_high_s);
        end
    end

    // Droop reset stays until the supply recovers
    wire [3:0] src_now  = {droop_rst_r, por_s, wdt_s, ~pin_n_s};
    wire       any_src  = |src_now;

    // ----------------------------------------
    // Reset sequencer
    // ----------------------------------------
    always @(posedge CORE_CLK_I) begin
        if (!NRST_I) begin
            state_r <= ST_HOLD;
            cnt_r   <= {`SRBC_CNT_W{1'b0}};
        end else if (any_src) begin
            state_r <= ST_HOLD;
            cnt_r   <= {`SRBC_CNT_W{1'b0}};
        end else begin
            case (state_r)
                ST_HOLD: begin
                    if (pin_n_s && osc_s) begin
                        state_r <= ST_COUNT;
                    end
                end
                ST_COUNT: begin
                    if (!osc_s) begin
                        state_r <= ST_HOLD;
                        cnt_r   <= {`SRBC_CNT_W{1'b0}};
                    end else if (cnt_r == WAKE_CNT - 16'h0001) begin
                        state_r <= ST_FLASH;
                    end else begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
                ST_FLASH: begin
                    if (finit_s) begin
                        state_r <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    state_r <= ST_RUN;
                end
                default: begin
                    state_r <= ST_HOLD;
                end
            endcase
        end
    end

    // Release waits for the sequencer
    wire in_reset = any_src || (state_r != ST_RUN);

    // ----------------------------------------
    // Flash wake-up timer after power-down
    // ----------------------------------------
    wire ext_wake = |(ext_sync & ext_wake_en_r);

    always @(posedge CORE_CLK_I) begin
        if (!NRST_I || in_reset) begin
            pd_r    <= 1'b0;
            fwait_r <= 1'b0;
            fcnt_r  <= {`SRBC_CNT_W{1'b0}};
        end else begin
            pd_r <= POWER_DOWN_I && !ext_wake;
            if (pd_r && ext_wake) begin
                fwait_r <= 1'b1;
                fcnt_r  <= {`SRBC_CNT_W{1'b0}};
            end else if (fwait_r) begin
                if (fcnt_r == FLASH_CNT - 16'h0001) begin
                    fwait_r <= 1'b0;
                end else begin
                    fcnt_r <= fcnt_r + 16'h0001;
                end
            end
        end
    end

    // ----------------------------------------
    // Guard level, latched once from flash
    // ----------------------------------------
    always @(posedge CORE_CLK_I) begin
        if (!NRST_I) begin
            guard_r    <= `SRBC_LVL_NONE;
            guard_ok_r <= 1'b0;
        end else if (!guard_ok_r && GUARD_WORD_VALID_I) begin
            guard_r    <= guard_decode(GUARD_WORD_I);
            guard_ok_r <= 1'b1;
        end
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    wire       apb_acc = PSEL_I && PENABLE_I && !PREADY_O;
    wire       apb_wr  = apb_acc && PWRITE_I;
    wire       hit     = (PADDR_I[11:5] == 7'h00) && (PADDR_I[1:0] == 2'h0);
    wire       wr_clr  = apb_wr && hit && (PADDR_I == `SRBC_OFS_CLEAR);
    wire [`SRBC_EV_W-1:0] ev_now;
    reg                   ext_prev_r;
    wire                  ext_lvl = |(ext_sync & ext_en_r);

    assign ev_now = {fwait_r && (fcnt_r == FLASH_CNT - 16'h0001), pd_r && ext_wake, droop_irq_r};

    reg [31:0] rd_nxt;
    always @* begin
        rd_nxt = 32'h00000000;
        case (PADDR_I)
            `SRBC_OFS_STATUS: rd_nxt[`SRBC_EV_W-1:0] = status_r;
            `SRBC_OFS_ENABLE: rd_nxt[`SRBC_EV_W-1:0] = enable_r;
            `SRBC_OFS_RAW:    rd_nxt[0]              = droop_irq_r;
            `SRBC_OFS_MEMMAP: rd_nxt[1:0]            = memmap_r;
            `SRBC_OFS_GUARD:  rd_nxt[1:0]            = guard_r;
            `SRBC_OFS_RSTSRC: rd_nxt[3:0]            = rstsrc_r;
            `SRBC_OFS_EXTCFG: rd_nxt[7:0]            = {ext_wake_en_r, ext_en_r};
            default:          rd_nxt                 = 32'h00000000;
        endcase
    end

    always @(posedge CORE_CLK_I) begin
        if (!NRST_I || in_reset) begin
            PREADY_O      <= 1'b0;
            PSLVERR_O     <= 1'b0;
            PRDATA_O      <= 32'h00000000;
            status_r      <= {`SRBC_EV_W{1'b0}};
            enable_r      <= {`SRBC_EV_W{1'b0}};
            memmap_r      <= `SRBC_MAP_BOOTROM;
            ext_wake_en_r <= 4'h0;
            ext_en_r      <= 4'h0;
            ext_prev_r    <= 1'b0;
        end else begin
            PREADY_O   <= apb_acc;
            PSLVERR_O  <= apb_acc && !hit;
            PRDATA_O   <= (apb_acc && !PWRITE_I && hit) ? rd_nxt : 32'h00000000;
            ext_prev_r <= ext_lvl;
            // Set wins over a simultaneous clear
            status_r <= (status_r & ~(wr_clr ? PWDATA_I[`SRBC_EV_W-1:0] : {`SRBC_EV_W{1'b0}}))
                        | ev_now;
            if (apb_wr && hit) begin
                case (PADDR_I)
                    `SRBC_OFS_ENABLE: enable_r <= PWDATA_I[`SRBC_EV_W-1:0];
                    `SRBC_OFS_MEMMAP: memmap_r <= (PWDATA_I[1:0] == 2'h3) ? memmap_r : PWDATA_I[1:0];
                    `SRBC_OFS_EXTCFG: begin
                        ext_en_r      <= PWDATA_I[3:0];
                        ext_wake_en_r <= PWDATA_I[7:4];
                    end
                    default: begin
                        enable_r <= enable_r;
                    end
                endcase
            end
        end
    end

    // Reset cause survives internal reset; write ones to clear
    always @(posedge CORE_CLK_I) begin
        if (!NRST_I) begin
            rstsrc_r <= 4'h0;
        end else begin
            rstsrc_r <= (rstsrc_r & ~((apb_wr && PADDR_I == `SRBC_OFS_RSTSRC) ? PWDATA_I[3:0] : 4'h0))
                        | src_now;
        end
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    always @(posedge CORE_CLK_I) begin
        if (!NRST_I) begin
            SYS_RST_N_O              <= 1'b0;
            DROOP_IRQ_O              <= 1'b0;
            IRQ_O                    <= 1'b0;
            EXT_IRQ_O                <= 4'h0;
            EDGE_IRQ_O               <= 68'h0;
            WAKE_O                   <= 1'b0;
            FLASH_ACCESS_OK_O        <= 1'b0;
            VECTOR_MAP_O             <= `SRBC_MAP_BOOTROM;
            GUARD_LEVEL_O            <= `SRBC_LVL_NONE;
            DEBUG_BLOCK_O            <= 1'b1;
            LOADER_ALLOW_O           <= 1'b0;
            LOADER_OVERRIDE_ALLOW_O  <= 1'b0;
            LOADER_SECTOR0_BLOCK_O   <= 1'b1;
            LOADER_FULL_ERASE_ONLY_O <= 1'b0;
            APP_FLASH_CALLS_ALLOW_O  <= 1'b0;
        end else begin
            SYS_RST_N_O              <= !in_reset;
            DROOP_IRQ_O              <= droop_irq_r;
            IRQ_O                    <= |(status_r & enable_r);
            EXT_IRQ_O                <= ext_sync & ext_en_r;
            EDGE_IRQ_O               <= EDGE_IRQ_I;
            WAKE_O                   <= pd_r && ext_wake && !ext_prev_r;
            FLASH_ACCESS_OK_O        <= !in_reset && !fwait_r && !(pd_r && ext_wake);
            VECTOR_MAP_O             <= memmap_r;
            GUARD_LEVEL_O            <= guard_r;
            DEBUG_BLOCK_O            <= !guard_ok_r || (guard_r != `SRBC_LVL_NONE);
            LOADER_ALLOW_O           <= guard_ok_r && (guard_r != `SRBC_LVL_LOCKED);
            LOADER_OVERRIDE_ALLOW_O  <= guard_ok_r && (guard_r != `SRBC_LVL_LOCKED);
            LOADER_SECTOR0_BLOCK_O   <= !guard_ok_r || (guard_r == `SRBC_LVL_PARTIAL);
            LOADER_FULL_ERASE_ONLY_O <= guard_ok_r && (guard_r == `SRBC_LVL_FULLERA);
            APP_FLASH_CALLS_ALLOW_O  <= !in_reset;
        end
    end

endmodule // srbc_top

`default_nettype wire

// File: tb/srbc_top_asserts.sv
// Port-level checker for srbc_top.
// Assumes it is bound to srbc_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module srbc_chk (
    input wire logic       CORE_CLK_I,
    input wire logic       NRST_I,
    input wire logic       PSEL_I,
    input wire logic       PENABLE_I,
    input wire logic       PREADY_O,
    input wire logic       RESET_PIN_N_I,
    input wire logic       WDT_RESET_I,
    input wire logic       POR_I,
    input wire logic       DROOP_IRQ_LOW_I,
    input wire logic       DROOP_RST_LOW_I,
    input wire logic       OSC_RUNNING_I,
    input wire logic       FLASH_INIT_DONE_I,
    input wire logic       SYS_RST_N_O,
    input wire logic       DROOP_IRQ_O,
    input wire logic       WAKE_O,
    input wire logic       FLASH_ACCESS_OK_O,
    input wire logic [1:0] VECTOR_MAP_O,
    input wire logic [1:0] GUARD_LEVEL_O,
    input wire logic       DEBUG_BLOCK_O,
    input wire logic       LOADER_ALLOW_O,
    input wire logic       LOADER_OVERRIDE_ALLOW_O,
    input wire logic       APP_FLASH_CALLS_ALLOW_O
);
    logic [15:0] low_cnt;

    // Cycles in internal reset
    always @(posedge CORE_CLK_I) begin
        if (!NRST_I || SYS_RST_N_O)
            low_cnt <= 16'h0000;
        else if (low_cnt != 16'hFFFF)
            low_cnt <= low_cnt + 16'h0001;
    end

    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!NRST_I);

    property p_pin_rst; !RESET_PIN_N_I [*5] |-> ##[0:6] !SYS_RST_N_O; endproperty
    a_pin_rst: assert property (p_pin_rst) else $error("pin reset missed");
    property p_src_rst; (WDT_RESET_I || POR_I) [*5] |-> ##[0:6] !SYS_RST_N_O; endproperty
    a_src_rst: assert property (p_src_rst) else $error("source reset missed");
    property p_droop_rst; DROOP_RST_LOW_I [*5] |-> ##[0:6] !SYS_RST_N_O; endproperty
    a_droop_rst: assert property (p_droop_rst) else $error("droop reset missed");
    property p_rel_cnt; $rose(SYS_RST_N_O) |-> low_cnt >= 16'h0400; endproperty
    a_rel_cnt: assert property (p_rel_cnt) else $error("release too early");
    property p_rel_cond;
        $rose(SYS_RST_N_O) |-> $past(FLASH_INIT_DONE_I, 4) && $past(OSC_RUNNING_I, 4) && $past(RESET_PIN_N_I, 4);
    endproperty
    a_rel_cond: assert property (p_rel_cond) else $error("release without conditions");
    property p_map_rst; !SYS_RST_N_O ##1 !SYS_RST_N_O |-> VECTOR_MAP_O == 2'h0; endproperty
    a_map_rst: assert property (p_map_rst) else $error("map not boot rom in reset");
    property p_apb; PSEL_I && PENABLE_I && !PREADY_O && SYS_RST_N_O |=> PREADY_O; endproperty
    a_apb: assert property (p_apb) else $error("no ready");
    property p_droop_irq; DROOP_IRQ_LOW_I [*6] |-> ##[0:4] DROOP_IRQ_O; endproperty
    a_droop_irq: assert property (p_droop_irq) else $error("droop request missed");
    property p_guard; GUARD_LEVEL_O != 2'h0 |-> DEBUG_BLOCK_O; endproperty
    a_guard: assert property (p_guard) else $error("debug open under guard");
    property p_locked; GUARD_LEVEL_O == 2'h3 |-> !LOADER_ALLOW_O && !LOADER_OVERRIDE_ALLOW_O; endproperty
    a_locked: assert property (p_locked) else $error("loader open when locked");
    property p_app; SYS_RST_N_O [*2] |-> APP_FLASH_CALLS_ALLOW_O; endproperty
    a_app: assert property (p_app) else $error("app flash calls blocked");
    property p_wake; WAKE_O |-> ##[0:2] !FLASH_ACCESS_OK_O; endproperty
    a_wake: assert property (p_wake) else $error("flash open after wake");
endmodule // srbc_chk

bind srbc_top srbc_chk i_chk (.*);
`default_nettype wire

// File: tb/srbc_flash_model.sv
// Flash controller stand-in: init done, then the guard word.
// Assumes a synchronous active-low reset from the bench.
`timescale 1ns/1ps
`default_nettype none
module srbc_flash_model #(
    parameter int INIT_CLKS = 2000
) (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic [31:0] guard_i,
    output logic             done_o,
    output logic             valid_o,
    output logic      [31:0] word_o
);
    int cnt;

    // Word toggles until init ends
    always @(posedge clk_i) begin
        valid_o <= done_o;
        if (!nrst_i) begin
            cnt    <= 0;
            done_o <= 1'b0;
            word_o <= ~guard_i;
        end else begin
            if (cnt < INIT_CLKS)
                cnt <= cnt + 1;
            else
                done_o <= 1'b1;
            word_o <= done_o ? guard_i : ~word_o;
        end
    end
endmodule // srbc_flash_model
`default_nettype wire

// File: tb/tb.sv
// Bench for srbc_top with a flash model.
// Assumes design, checker and model files are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "srbc_defines.vh"
module tb;
    logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pdn = 1'b0, osc = 1'b1;
    logic        pin_n = 1'b1, wdt = 1'b0, por = 1'b0, irq_lo = 1'b0, irq_hi = 1'b1, rst_lo = 1'b0, rst_hi = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, gpat = 32'h0, rd, prdata, gword;
    logic [3:0]  ext = 4'h0, ext_o;
    logic [67:0] edge_i = 68'h0, edge_o;
    logic [1:0]  vmap, glvl;
    logic        er, pready, pslverr, sys_n, droop, irq, wake, fok, dbg, ldr, ovr, sec0, fea, app, fdone, gvalid;
    logic [31:0] pats [4] = '{`SRBC_PAT_PARTIAL, `SRBC_PAT_FULLERA, `SRBC_PAT_LOCKED, 32'h0};
    logic [7:0]  exps [4] = '{8'h7D, 8'hBB, 8'hE1, 8'h19};
    logic [7:0]  msks [4] = '{8'hFF, 8'hFF, 8'hF9, 8'hFF};
    int          n_errors = 0, checks = 0, k;

    srbc_top i_srbc_top (.CORE_CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .RESET_PIN_N_I(pin_n), .WDT_RESET_I(wdt), .POR_I(por), .DROOP_IRQ_LOW_I(irq_lo), .DROOP_IRQ_HIGH_I(irq_hi),
        .DROOP_RST_LOW_I(rst_lo), .DROOP_RST_HIGH_I(rst_hi), .OSC_RUNNING_I(osc), .FLASH_INIT_DONE_I(fdone),
        .GUARD_WORD_I(gword), .GUARD_WORD_VALID_I(gvalid), .POWER_DOWN_I(pdn), .EXT_IRQ_I(ext), .EDGE_IRQ_I(edge_i),
        .SYS_RST_N_O(sys_n), .DROOP_IRQ_O(droop), .IRQ_O(irq), .EXT_IRQ_O(ext_o), .EDGE_IRQ_O(edge_o), .WAKE_O(wake),
        .FLASH_ACCESS_OK_O(fok), .VECTOR_MAP_O(vmap), .GUARD_LEVEL_O(glvl), .DEBUG_BLOCK_O(dbg), .LOADER_ALLOW_O(ldr),
        .LOADER_OVERRIDE_ALLOW_O(ovr), .LOADER_SECTOR0_BLOCK_O(sec0), .LOADER_FULL_ERASE_ONLY_O(fea),
        .APP_FLASH_CALLS_ALLOW_O(app));
    srbc_flash_model #(.INIT_CLKS(2000)) i_srbc_flash_model (.clk_i(clk), .nrst_i(nrst), .guard_i(gpat),
        .done_o(fdone), .valid_o(gvalid), .word_o(gword));

    initial begin
        forever #2 clk = ~clk;
    end

    task chk(input string nm, input logic [67:0] e, input logic [67:0] g);
        checks++;
        if (g !== e) begin
            $display("unexpected %s exp %h got %h", nm, e, g);
            n_errors++;
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        rd = prdata;
        er = pslverr;
        chk("pready", 1, pready);
        if (pready !== 1'b1) close_out();
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask

    task wrel;
        for (k = 0; k < 3000 && sys_n !== 1'b1; k++) @(posedge clk);
        chk("release", 1, sys_n);
        if (sys_n !== 1'b1) close_out();
    endtask

    task close_out;
        if (n_errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        for (int r = 0; r < 4; r++) begin
            gpat <= pats[r];
            nrst <= 1'b0;
            repeat (10) @(posedge clk);
            nrst <= 1'b1;
            repeat (1500) @(posedge clk);
            chk("early release", 0, sys_n);
            wrel();
            repeat (2) @(posedge clk);
            chk("guard", exps[r], {glvl, dbg, ldr, ovr, sec0, fea, app} & msks[r]);
            chk("map", `SRBC_MAP_BOOTROM, vmap);
        end
        apb(1'b0, `SRBC_OFS_STATUS, 0);
        chk("status", 0, rd);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, `SRBC_OFS_MEMMAP, m);
            apb(1'b0, `SRBC_OFS_MEMMAP, 0);
            chk("memmap", (m == 3) ? 2 : m, rd);
            chk("map pins", (m == 3) ? 2 : m, vmap);
        end
        apb(1'b0, 12'h020, 0);
        chk("unmapped", 1, er);
        for (int en = 1; en >= 0; en--) begin
            apb(1'b1, `SRBC_OFS_ENABLE, en);
            irq_hi <= 1'b0;
            irq_lo <= 1'b1;
            repeat (12) @(posedge clk);
            chk("droop", 1, droop);
            chk("irq", en, irq);
            apb(1'b0, `SRBC_OFS_RAW, 0);
            chk("raw", 1, rd[0]);
            irq_lo <= 1'b0;
            repeat (12) @(posedge clk);
            chk("droop hyst", 1, droop);
            irq_hi <= 1'b1;
            repeat (12) @(posedge clk);
            chk("droop off", 0, droop);
            apb(1'b0, `SRBC_OFS_STATUS, 0);
            chk("sticky", 1, rd[0]);
            apb(1'b1, `SRBC_OFS_CLEAR, 1);
            apb(1'b0, `SRBC_OFS_STATUS, 0);
            chk("cleared", 0, rd[0]);
            chk("irq off", 0, irq);
        end
        apb(1'b1, `SRBC_OFS_EXTCFG, 32'h11);
        pdn <= 1'b1;
        ext <= 4'h1;
        for (k = 0; k < 20 && wake !== 1'b1; k++) @(posedge clk);
        chk("wake", 1, wake);
        repeat (2) @(posedge clk);
        chk("flash wait", 0, fok);
        chk("ext out", 1, ext_o);
        for (k = 0; k < 26000 && fok !== 1'b1; k++) @(posedge clk);
        chk("flash ok", 1, fok & (k > 24990));
        pdn <= 1'b0;
        ext <= 4'h0;
        edge_i <= {4'h8, 64'h1};
        repeat (3) @(posedge clk);
        chk("edge", {4'h8, 64'h1}, edge_o);
        for (int s = 0; s < 3; s++) begin
            apb(1'b1, `SRBC_OFS_RSTSRC, 32'hF);
            apb(1'b1, `SRBC_OFS_MEMMAP, 2);
            pin_n  <= (s != 0);
            wdt    <= (s == 1);
            rst_hi <= (s != 2);
            rst_lo <= (s == 2);
            repeat (8) @(posedge clk);
            chk("src rst", 0, sys_n);
            por    <= (s == 2);
            pin_n  <= 1'b1;
            wdt    <= 1'b0;
            rst_lo <= 1'b0;
            repeat (30) @(posedge clk);
            chk("reset hold", 0, sys_n);
            por    <= 1'b0;
            rst_hi <= 1'b1;
            wrel();
            chk("map reset", `SRBC_MAP_BOOTROM, vmap);
            apb(1'b0, `SRBC_OFS_RSTSRC, 0);
            chk("cause", 1, rd[(s == 2) ? 3 : s]);
        end
        close_out();
    end
endmodule // tb
`default_nettype wire
